// ### pkg/slg_pkg.sv
package slg_pkg;
    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 10;
    localparam int SAMPLE_PERIOD_NS = 1000000;
    localparam int SAMPLE_CYCLES = SAMPLE_PERIOD_NS / CLK_PERIOD_NS;
    localparam int SAMPLE_RATE_HZ = 1000000000 / SAMPLE_PERIOD_NS;
    localparam int PERMIT_TIME_MIN = 30;
    localparam int PERMIT_TICKS = PERMIT_TIME_MIN * 60 * SAMPLE_RATE_HZ;
    // ----------------------------------------------------------------
    // Scaling (frequencies in 0.01 Hz, gains and Q in 8.8 fixed point)
    // ----------------------------------------------------------------
    localparam logic [15:0] LP_BYPASS_CHZ = 16'h0636;   // 15.9 Hz
    localparam logic [15:0] NOTCH_FMIN_CHZ = 16'h0001;  // 0.01 Hz
    localparam logic [15:0] NOTCH_FMAX_CHZ = 16'h0640;  // 16.0 Hz
    localparam logic [15:0] NOTCH_QMIN = 16'h00b5;      // 0.707
    localparam logic [15:0] NOTCH_QMAX = 16'h1900;      // 25.0
    // 2*pi*T scaled to Q16 per 0.01 Hz, times 256
    localparam logic [31:0] FREQ_COEF_K = 32'h0000041e;
    localparam logic [15:0] DEMAND_MAX = 16'h2710;      // 100.00 %
    localparam logic [15:0] PCT_UNITS = 16'h0064;       // units per 1 %
    localparam logic [15:0] GAIN_RESET = 16'h0100;      // 1.0
    localparam logic [15:0] DEMAND_RESET = 16'h0000;
    // ----------------------------------------------------------------
    // State types
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [31:0] acc;
    } slg_lp_state_t;

    typedef struct packed {
        logic [31:0] tick_cnt;
        logic tick;
        logic [16:0] recip_span;
        logic [16:0] ki;
        logic [15:0] lp_eng_a;
        logic [15:0] lp_trb_a;
        logic [16:0] nf_f;
        logic [16:0] qinv;
        logic [16:0] depth;
        logic signed [31:0] nf_low;
        logic signed [31:0] nf_band;
        logic [15:0] comp_speed;
        logic signed [31:0] integ;
        logic signed [31:0] err_prev;
        logic [15:0] gain;
        logic [15:0] demand;
        logic trig_prev;
        logic permit_prev;
        logic [31:0] permit_cnt;
        logic [15:0] dip_cnt;
    } slg_state_t;
endpackage

// ### verilog/slg_lowpass.sv
`timescale 1ns/1ns
`default_nettype none
module slg_lowpass (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic tick_in,
    input wire logic enable_in,
    input wire logic [15:0] alpha_in,
    input wire logic [15:0] x_in,
    output logic [15:0] y_out
);
    import slg_pkg::*;

    slg_lp_state_t s_q;
    slg_lp_state_t s_d;
    logic signed [47:0] step;

    // ----------------------------------------------------------------
    // First-order section, y += alpha * (x - y)
    // ----------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        step = ($signed({16'h0000, x_in, 16'h0000})
            - $signed({16'h0000, s_q.acc})) * $signed({1'b0, alpha_in});
        if (tick_in) begin
            if (enable_in) begin
                s_d.acc = s_q.acc + 32'(step >>> 16);
            end else begin
                // Bypass keeps the state tracking, so enabling is bumpless
                s_d.acc = {x_in, 16'h0000};
            end
        end
    end

    // State register
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign y_out = s_q.acc[31:16];
endmodule
`default_nettype wire

// ### verilog/slg_speed_loop.sv
`timescale 1ns/1ns
`default_nettype none
module slg_speed_loop #(
    parameter int SAMPLE_CYCLES_P = slg_pkg::SAMPLE_CYCLES,
    parameter int PERMIT_TICKS_P = slg_pkg::PERMIT_TICKS
) (
    input wire logic clk_in,
    input wire logic reset_n_in,
    input wire logic [15:0] engine_speed_in,
    input wire logic [15:0] turbo_speed_in,
    input wire logic [15:0] speed_setpoint_in,
    input wire logic [15:0] min_speed_in,
    input wire logic [15:0] rated_speed_in,
    input wire logic [15:0] low_gain_in,
    input wire logic [15:0] rated_gain_in,
    input wire logic [15:0] gain_ratio_in,
    input wire logic [15:0] error_band_in,
    input wire logic [15:0] load_gain_breakpoint_in,
    input wire logic signed [15:0] load_gain_slope_in,
    input wire logic [15:0] integral_time_in,
    input wire logic [15:0] compensation_in,
    input wire logic [15:0] engine_speed_lowpass_cutoff_in,
    input wire logic [15:0] turbo_speed_lowpass_cutoff_in,
    input wire logic turbo_pickup_enable_in,
    input wire logic bandstop_enable_in,
    input wire logic [15:0] bandstop_center_freq_in,
    input wire logic [15:0] bandstop_q_in,
    input wire logic fuel_dip_trigger_in,
    input wire logic fuel_dip_permit_in,
    input wire logic [15:0] fuel_dip_magnitude_in,
    input wire logic [15:0] fuel_dip_duration_in,
    output logic [15:0] fuel_demand_out,
    output logic [15:0] comp_speed_out,
    output logic [15:0] turbo_speed_filt_out,
    output logic [15:0] loop_gain_out,
    output logic fuel_dip_active_out,
    output logic fuel_dip_permit_active_out,
    output logic sample_strobe_out
);
    import slg_pkg::*;

    // ----------------------------------------------------------------
    // Arithmetic helpers
    // ----------------------------------------------------------------
    // Reciprocal-style divide, saturating; a zero divisor gives max
    function automatic logic [16:0] udiv(input logic [31:0] num,
                                         input logic [15:0] den);
        logic [31:0] q;
        q = (den == 16'h0000) ? 32'hffffffff : num / {16'h0000, den};
        udiv = (q > 32'h0001ffff) ? 17'h1ffff : q[16:0];
    endfunction

    // Signed value times unsigned Q16 factor
    function automatic logic signed [31:0] mulq16(
            input logic signed [31:0] a, input logic [16:0] k);
        logic signed [63:0] p;
        p = 64'(a) * $signed({47'h0, k});
        mulq16 = 32'(p >>> 16);
    endfunction

    function automatic logic [15:0] clamp16(input logic signed [31:0] v,
                                            input logic [15:0] hi);
        if (v < 0) begin
            clamp16 = 16'h0000;
        end else if (v > $signed({16'h0000, hi})) begin
            clamp16 = hi;
        end else begin
            clamp16 = v[15:0];
        end
    endfunction

    function automatic logic [15:0] lp_alpha(input logic [15:0] fc);
        logic [31:0] a;
        a = ({16'h0000, fc} * FREQ_COEF_K) >> 8;
        lp_alpha = (a > 32'h0000ffff) ? 16'hffff : a[15:0];
    endfunction

    // ----------------------------------------------------------------
    // Reset release
    // ----------------------------------------------------------------
    logic [1:0] rst_sync_q;
    logic rst_n;

    // Async assert, two-flop release
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            rst_sync_q <= 2'b00;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_q[1];

    // ----------------------------------------------------------------
    // Speed input low-pass sections
    // ----------------------------------------------------------------
    slg_state_t s_q;
    slg_state_t s_d;
    logic [15:0] eng_lp;
    logic [15:0] trb_lp;
    logic eng_lp_en;
    logic trb_lp_en;

    assign eng_lp_en = engine_speed_lowpass_cutoff_in < LP_BYPASS_CHZ;
    assign trb_lp_en = turbo_pickup_enable_in
        && (turbo_speed_lowpass_cutoff_in < LP_BYPASS_CHZ);

    slg_lowpass u_eng_lp (
        .clk_in(clk_in),
        .rst_n_in(rst_n),
        .tick_in(s_q.tick),
        .enable_in(eng_lp_en),
        .alpha_in(s_q.lp_eng_a),
        .x_in(engine_speed_in),
        .y_out(eng_lp)
    );

    slg_lowpass u_trb_lp (
        .clk_in(clk_in),
        .rst_n_in(rst_n),
        .tick_in(s_q.tick),
        .enable_in(trb_lp_en),
        .alpha_in(s_q.lp_trb_a),
        .x_in(turbo_speed_in),
        .y_out(trb_lp)
    );

    // ----------------------------------------------------------------
    // Loop datapath
    // ----------------------------------------------------------------
    logic [15:0] f_cl;
    logic [15:0] q_cl;
    logic [15:0] span;
    logic signed [31:0] x8;
    logic signed [31:0] high;
    logic signed [31:0] bp_norm;
    logic signed [31:0] nf_out;
    logic [15:0] comp;
    logic [15:0] spd_cl;
    logic signed [31:0] err;
    logic [31:0] err_abs;
    logic signed [31:0] g;
    logic signed [31:0] p_term;
    logic signed [31:0] lead;
    logic signed [31:0] sum;
    logic [15:0] dmd;
    logic permit_act;

    always_comb begin
        s_d = s_q;
        // Sample strobe from a free-running divider
        s_d.tick = 1'b0;
        if (s_q.tick_cnt >= 32'(SAMPLE_CYCLES_P - 1)) begin
            s_d.tick_cnt = 32'h00000000;
            s_d.tick = 1'b1;
        end else begin
            s_d.tick_cnt = s_q.tick_cnt + 32'h00000001;
        end

        // Coefficients follow the settings every clock
        s_d.lp_eng_a = lp_alpha(engine_speed_lowpass_cutoff_in);
        s_d.lp_trb_a = lp_alpha(turbo_speed_lowpass_cutoff_in);
        f_cl = bandstop_center_freq_in;
        if (f_cl < NOTCH_FMIN_CHZ) f_cl = NOTCH_FMIN_CHZ;
        if (f_cl > NOTCH_FMAX_CHZ) f_cl = NOTCH_FMAX_CHZ;
        q_cl = bandstop_q_in;
        if (q_cl < NOTCH_QMIN) q_cl = NOTCH_QMIN;
        if (q_cl > NOTCH_QMAX) q_cl = NOTCH_QMAX;
        s_d.nf_f = {1'b0, lp_alpha(f_cl)};
        s_d.qinv = udiv(32'h01000000, q_cl);
        // Depth 1 - 0.707/Q leaves 0.707/Q at the centre
        s_d.depth = 17'h10000
            - udiv({NOTCH_QMIN, 16'h0000}, q_cl);
        span = (rated_speed_in > min_speed_in)
            ? rated_speed_in - min_speed_in : 16'h0000;
        // Larger integral time gives a smaller integral step
        s_d.ki = udiv(32'h00010000, integral_time_in);

        // State-variable bandstop on the filtered engine speed
        x8 = $signed({8'h00, eng_lp, 8'h00});
        s_d.nf_low = s_q.nf_low + mulq16(s_q.nf_band, s_q.nf_f);
        high = x8 - s_d.nf_low - mulq16(s_q.nf_band, s_q.qinv);
        s_d.nf_band = s_q.nf_band + mulq16(high, s_q.nf_f);
        bp_norm = mulq16(s_d.nf_band, s_q.qinv);
        nf_out = x8 - mulq16(bp_norm, s_q.depth);
        if (!bandstop_enable_in) begin
            // Parked states avoid a step when the filter is switched in
            s_d.nf_low = x8;
            s_d.nf_band = 32'sh0;
            nf_out = x8;
        end
        comp = clamp16(nf_out >>> 8, 16'hffff);

        // Base gain across the speed range
        spd_cl = comp;
        if (spd_cl < min_speed_in) spd_cl = min_speed_in;
        if (spd_cl > rated_speed_in) spd_cl = rated_speed_in;
        if (span == 16'h0000) spd_cl = min_speed_in;
        // Position in the span as a Q16 fraction; dividing the offset
        // keeps both end points exact, a rounded reciprocal would not
        s_d.recip_span = (span == 16'h0000) ? 17'h00000
            : udiv({spd_cl - min_speed_in, 16'h0000}, span);
        g = $signed({16'h0000, low_gain_in}) + mulq16(
            $signed({16'h0000, rated_gain_in})
                - $signed({16'h0000, low_gain_in}),
            s_q.recip_span);

        // Window on compensated error switches in the ratio
        err = $signed({16'h0000, speed_setpoint_in})
            - $signed({16'h0000, comp});
        err_abs = (err < 0) ? 32'(-err) : 32'(err);
        if (err_abs > {16'h0000, error_band_in}) begin
            g = (g * $signed({16'h0000, gain_ratio_in})) >>> 8;
        end

        // Load-dependent slope above the breakpoint only
        if (s_q.demand > load_gain_breakpoint_in) begin
            g = g + (32'(load_gain_slope_in)
                * $signed({16'h0000, s_q.demand - load_gain_breakpoint_in}))
                / $signed({16'h0000, PCT_UNITS});
        end
        s_d.gain = clamp16(g, 16'hffff);

        // Proportional, integral and lead terms
        p_term = (err * $signed({16'h0000, s_d.gain})) >>> 8;
        lead = ((err - s_q.err_prev)
            * $signed({16'h0000, compensation_in})) >>> 8;
        s_d.integ = s_q.integ + mulq16(p_term <<< 8, s_q.ki);
        // Clamp holds the integrator within 0 to DEMAND_MAX to bound wind-up
        if (s_d.integ < 0) s_d.integ = 32'sh0;
        if (s_d.integ > $signed({8'h00, DEMAND_MAX, 8'h00})) begin
            s_d.integ = $signed({8'h00, DEMAND_MAX, 8'h00});
        end
        sum = p_term + (s_d.integ >>> 8) + lead;
        dmd = clamp16(sum, DEMAND_MAX);

        // Fuel-dip permit window, restarted by each rising edge
        s_d.permit_prev = fuel_dip_permit_in;
        if (!fuel_dip_permit_in) begin
            s_d.permit_cnt = 32'h00000000;
        end else if (!s_q.permit_prev) begin
            s_d.permit_cnt = 32'(PERMIT_TICKS_P);
        end else if (s_q.tick && s_q.permit_cnt != 32'h00000000) begin
            s_d.permit_cnt = s_q.permit_cnt - 32'h00000001;
        end
        permit_act = fuel_dip_permit_in && s_q.permit_cnt != 32'h00000000;

        // Trigger acts on its falling edge, one dip per toggle
        s_d.trig_prev = fuel_dip_trigger_in;
        if (s_q.trig_prev && !fuel_dip_trigger_in && permit_act) begin
            s_d.dip_cnt = fuel_dip_duration_in;
        end else if (s_q.tick && s_q.dip_cnt != 16'h0000) begin
            s_d.dip_cnt = s_q.dip_cnt - 16'h0001;
        end

        // Sampled outputs
        if (s_q.tick) begin
            s_d.comp_speed = comp;
            s_d.err_prev = err;
            if (s_q.dip_cnt != 16'h0000) begin
                dmd = (dmd > fuel_dip_magnitude_in)
                    ? dmd - fuel_dip_magnitude_in : 16'h0000;
            end
            s_d.demand = dmd;
        end else begin
            // Hold all loop state between samples
            s_d.nf_low = s_q.nf_low;
            s_d.nf_band = s_q.nf_band;
            s_d.integ = s_q.integ;
            s_d.gain = s_q.gain;
        end
    end

    // State register
    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= '0;
            s_q.gain <= GAIN_RESET;
            s_q.demand <= DEMAND_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    // ----------------------------------------------------------------
    // Output flops
    // ----------------------------------------------------------------
    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            fuel_demand_out <= DEMAND_RESET;
            comp_speed_out <= 16'h0000;
            turbo_speed_filt_out <= 16'h0000;
            loop_gain_out <= GAIN_RESET;
            fuel_dip_active_out <= 1'b0;
            fuel_dip_permit_active_out <= 1'b0;
            sample_strobe_out <= 1'b0;
        end else begin
            fuel_demand_out <= s_q.demand;
            comp_speed_out <= s_q.comp_speed;
            turbo_speed_filt_out <= turbo_pickup_enable_in ? trb_lp : 16'h0000;
            loop_gain_out <= s_q.gain;
            fuel_dip_active_out <= s_q.dip_cnt != 16'h0000;
            fuel_dip_permit_active_out <= fuel_dip_permit_in
                && s_q.permit_cnt != 32'h00000000;
            sample_strobe_out <= s_q.tick;
        end
    end
endmodule
`default_nettype wire

// ### testbench/slg_pickup_model.sv
`timescale 1ns/1ns
`default_nettype none
module slg_pickup_model (
    input wire logic clk_in,
    input wire logic [15:0] eng_rpm_in,
    input wire logic [15:0] trb_rpm_in,
    input wire logic [15:0] fuel_demand_in,
    input wire logic strobe_in,
    output logic [15:0] engine_speed_out,
    output logic [15:0] turbo_speed_out,
    output logic [15:0] act_pos_out
);
    // Pickups read zero until the first falling edge
    initial begin
        engine_speed_out = 16'h0000;
        turbo_speed_out = 16'h0000;
        act_pos_out = 16'h0000;
    end
    // Speeds move off the sampling edge, so no race with the block
    always @(negedge clk_in) begin
        engine_speed_out <= eng_rpm_in;
        turbo_speed_out <= trb_rpm_in;
    end
    // Actuator takes the demand of the previous sample at each strobe
    always @(posedge clk_in) begin
        if (strobe_in) begin
            act_pos_out <= fuel_demand_in;
        end
    end
endmodule
`default_nettype wire

// ### testbench/slg_speed_loop_assertions.sv
`timescale 1ns/1ns
`default_nettype none
module slg_speed_loop_checker #(
    parameter int SAMPLE_CYCLES_P = slg_pkg::SAMPLE_CYCLES,
    parameter int PERMIT_TICKS_P = slg_pkg::PERMIT_TICKS
) (
    input wire logic clk_in,
    input wire logic reset_n_in,
    input wire logic turbo_pickup_enable_in,
    input wire logic fuel_dip_trigger_in,
    input wire logic [15:0] fuel_dip_duration_in,
    input wire logic [15:0] fuel_demand_out,
    input wire logic [15:0] turbo_speed_filt_out,
    input wire logic fuel_dip_active_out,
    input wire logic fuel_dip_permit_active_out,
    input wire logic sample_strobe_out
);
    // ----------------------------------------------------------------
    // Helper counters
    // ----------------------------------------------------------------
    localparam int TOFF_LIM = 2 * SAMPLE_CYCLES_P + 3;
    int gap_q, toff_q, pstb_q, dstb_q;
    logic seen_q;
    // Counts grow freely; a run is far too short to overflow them
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            gap_q <= 0;
            seen_q <= 1'b0;
            toff_q <= 0;
            pstb_q <= 0;
            dstb_q <= 0;
        end else begin
            gap_q <= sample_strobe_out ? 0 : gap_q + 1;
            seen_q <= seen_q | sample_strobe_out;
            toff_q <= turbo_pickup_enable_in ? 0 : toff_q + 1;
            pstb_q <= fuel_dip_permit_active_out ?
                pstb_q + int'(sample_strobe_out) : 0;
            dstb_q <= fuel_dip_active_out ?
                dstb_q + int'(sample_strobe_out) : 0;
        end
    end
    // ----------------------------------------------------------------
    // Properties
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!reset_n_in);
    sequence s_trig_fall;
        $fell(fuel_dip_trigger_in) && fuel_dip_permit_active_out;
    endsequence
    sequence s_dip_end;
        $fell(fuel_dip_active_out);
    endsequence
    property p_pulse;
        sample_strobe_out |=> !sample_strobe_out;
    endproperty
    a_pulse: assert property (p_pulse) else $error("long strobe");
    property p_gap;
        sample_strobe_out && seen_q |-> gap_q == SAMPLE_CYCLES_P - 1;
    endproperty
    a_gap: assert property (p_gap) else $error("strobe gap");
    property p_hold;
        $changed(fuel_demand_out) |-> $past(sample_strobe_out);
    endproperty
    a_hold: assert property (p_hold) else $error("demand moved");
    property p_toff;
        toff_q >= TOFF_LIM |-> turbo_speed_filt_out == 16'h0000;
    endproperty
    a_toff: assert property (p_toff) else $error("turbo not zero");
    property p_plim;
        fuel_dip_permit_active_out |-> pstb_q <= PERMIT_TICKS_P + 1;
    endproperty
    a_plim: assert property (p_plim) else $error("permit late");
    property p_need;
        $rose(fuel_dip_active_out) |-> $past(fuel_dip_permit_active_out, 2);
    endproperty
    a_need: assert property (p_need) else $error("dip no permit");
    property p_fire;
        s_trig_fall ##1 (fuel_dip_permit_active_out &&
            fuel_dip_duration_in != 16'h0000) |-> ##[1:5] fuel_dip_active_out;
    endproperty
    a_fire: assert property (p_fire) else $error("dip missing");
    property p_len;
        s_dip_end |-> dstb_q >= int'(fuel_dip_duration_in) - 1 &&
            dstb_q <= int'(fuel_dip_duration_in) + 1;
    endproperty
    a_len: assert property (p_len) else $error("dip length");
endmodule
bind slg_speed_loop slg_speed_loop_checker #(
    .SAMPLE_CYCLES_P(SAMPLE_CYCLES_P),
    .PERMIT_TICKS_P(PERMIT_TICKS_P)
) u_chk (
    .clk_in(clk_in), .reset_n_in(reset_n_in),
    .turbo_pickup_enable_in(turbo_pickup_enable_in),
    .fuel_dip_trigger_in(fuel_dip_trigger_in),
    .fuel_dip_duration_in(fuel_dip_duration_in),
    .fuel_demand_out(fuel_demand_out),
    .turbo_speed_filt_out(turbo_speed_filt_out),
    .fuel_dip_active_out(fuel_dip_active_out),
    .fuel_dip_permit_active_out(fuel_dip_permit_active_out),
    .sample_strobe_out(sample_strobe_out)
);
`default_nettype wire

// ### testbench/slg_speed_loop_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module slg_speed_loop_tb_top;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [15:0] eng = 16'h05dc, trb = 16'h0000, setp = 16'h05dc;
    logic [15:0] min_s = 16'h03e8, rat_s = 16'h07d0, lo_g = 16'h0100;
    logic [15:0] rat_g = 16'h0300, ratio = 16'h0200, band = 16'h0032;
    logic [15:0] bp = 16'h2710, ti = 16'h0001, comp = 16'h0000;
    logic [15:0] eng_fc = 16'h0640, trb_fc = 16'h0640, nf_f = 16'h0640;
    logic [15:0] nf_q = 16'h00b5, mag = 16'h07d0, dur = 16'h0008;
    logic signed [15:0] slope = 16'sh0010;
    logic trb_en = 1'b0, nf_en = 1'b0, trig = 1'b0, permit = 1'b0;
    logic [15:0] demand, cspd, tspd, gain, eng_pin, trb_pin, act, d0, d1;
    logic dip_act, perm_act, strobe;
    int failures = 0, comparisons = 0, cycles = 0;
    // ----------------------------------------------------------------
    // Clock, far side and block
    // ----------------------------------------------------------------
    always #5 clk = ~clk;
    slg_pickup_model u_model (.clk_in(clk), .eng_rpm_in(eng),
        .trb_rpm_in(trb), .fuel_demand_in(demand), .strobe_in(strobe),
        .engine_speed_out(eng_pin), .turbo_speed_out(trb_pin),
        .act_pos_out(act));
    slg_speed_loop #(.SAMPLE_CYCLES_P(10), .PERMIT_TICKS_P(20)) DUT (
        .clk_in(clk), .reset_n_in(rst_n), .engine_speed_in(eng_pin),
        .turbo_speed_in(trb_pin), .speed_setpoint_in(setp),
        .min_speed_in(min_s), .rated_speed_in(rat_s), .low_gain_in(lo_g),
        .rated_gain_in(rat_g), .gain_ratio_in(ratio), .error_band_in(band),
        .load_gain_breakpoint_in(bp), .load_gain_slope_in(slope),
        .integral_time_in(ti), .compensation_in(comp),
        .engine_speed_lowpass_cutoff_in(eng_fc),
        .turbo_speed_lowpass_cutoff_in(trb_fc),
        .turbo_pickup_enable_in(trb_en), .bandstop_enable_in(nf_en),
        .bandstop_center_freq_in(nf_f), .bandstop_q_in(nf_q),
        .fuel_dip_trigger_in(trig), .fuel_dip_permit_in(permit),
        .fuel_dip_magnitude_in(mag), .fuel_dip_duration_in(dur),
        .fuel_demand_out(demand), .comp_speed_out(cspd),
        .turbo_speed_filt_out(tspd), .loop_gain_out(gain),
        .fuel_dip_active_out(dip_act),
        .fuel_dip_permit_active_out(perm_act),
        .sample_strobe_out(strobe));
    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value at %0t: %h expected %h", $time, seen, exp);
        end
    endtask
    // One sample is ten clocks with the shortened divider
    task automatic samples(input int n);
        repeat (n * 10) @(negedge clk);
    endtask
    task automatic do_reset;
        rst_n = 1'b0;
        repeat (4) @(negedge clk);
        rst_n = 1'b1;
    endtask
    task automatic end_of_test;
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // Hang guard, well above the few thousand cycles the run needs
    always @(posedge clk) begin
        cycles++;
        if (cycles == 40000) begin
            failures++;
            end_of_test();
        end
    end
    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_gain;
        setp = 16'h03e8;
        eng = 16'h03e8;
        samples(4);
        check(gain, 16'h0100);
        setp = 16'h07d0;
        eng = 16'h07d0;
        samples(4);
        check(gain, 16'h0300);
        setp = 16'h05dc;
        eng = 16'h05dc;
        samples(4);
        check(gain, 16'h0200);
        setp = 16'h0640;
        samples(3);
        check(gain, 16'h0400);
        setp = 16'h0578;
        samples(3);
        check(gain, 16'h0400);
        setp = 16'h060e;
        samples(3);
        check(gain, 16'h0200);
    endtask
    task automatic t_filter;
        eng_fc = 16'h0064;
        trb_fc = 16'h0064;
        trb_en = 1'b1;
        eng = 16'h07d0;
        trb = 16'h1000;
        samples(3);
        check(16'(cspd < 16'h0640), 16'h0001);
        check(16'(tspd < 16'h0800), 16'h0001);
        eng_fc = 16'h0636;
        trb_fc = 16'h0636;
        samples(3);
        check(cspd, 16'h07d0);
        check(tspd, 16'h1000);
        eng_fc = 16'h0635;
        eng = 16'h05dc;
        samples(3);
        check(16'(cspd > 16'h0700), 16'h0001);
        trb_en = 1'b0;
        samples(3);
        check(tspd, 16'h0000);
        eng_fc = 16'h0640;
        setp = 16'h05dc;
    endtask
    task automatic t_notch;
        nf_en = 1'b1;
        nf_f = 16'hffff;
        nf_q = 16'h0200;
        samples(400);
        check(16'(cspd >= 16'h05da && cspd <= 16'h05de), 16'h0001);
        nf_f = 16'h0000;
        nf_q = 16'h0000;
        samples(5);
        check(cspd, 16'h05dc);
        nf_en = 1'b0;
    endtask
    task automatic t_integ;
        do_reset();
        setp = 16'h0640;
        samples(2);
        d0 = demand;
        samples(4);
        d1 = demand;
        do_reset();
        ti = 16'h0004;
        samples(6);
        check(16'(d1 > demand), 16'h0001);
        ti = 16'h0001;
        // First sample after reset carries the lead of the error step
        do_reset();
        comp = 16'h0100;
        samples(2);
        check(16'(demand > d0), 16'h0001);
        comp = 16'h0000;
    endtask
    task automatic t_dip;
        do_reset();
        samples(80);
        setp = 16'h05dc;
        samples(6);
        check(act, 16'h2710);
        bp = 16'h2328;
        samples(3);
        check(gain, 16'h02a0);
        trig = 1'b1;
        samples(1);
        trig = 1'b0;
        samples(3);
        check(16'(dip_act), 16'h0000);
        check(demand, 16'h2710);
        permit = 1'b1;
        samples(1);
        check(16'(perm_act), 16'h0001);
        trig = 1'b1;
        samples(1);
        trig = 1'b0;
        samples(2);
        check(16'(dip_act), 16'h0001);
        check(demand, 16'h1f40);
        samples(8);
        check(16'(dip_act), 16'h0000);
        check(demand, 16'h2710);
        samples(12);
        check(16'(perm_act), 16'h0000);
        trig = 1'b1;
        samples(1);
        trig = 1'b0;
        samples(3);
        check(16'(dip_act), 16'h0000);
    endtask
    // Main sequence; later scenarios reset to clear the integrator
    initial begin
        do_reset();
        t_gain();
        t_filter();
        t_notch();
        t_integ();
        t_dip();
        end_of_test();
    end
endmodule
`default_nettype wire
